// file: radio_wake_decider.sv
// Purpose: Compares a correlator match count against the two thresholds.
// Assumes: Count is the number of chips matching the spreading sequence.
// Notes: Registered outputs, one cycle after a valid count.
`timescale 1ns/1ps
`default_nettype none
module radio_wake_decider (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire radio_wake_pkg::corr_in_t i_corr,
  input wire logic [6:0] i_thr_high,
  input wire logic [6:0] i_thr_low,
  output radio_wake_pkg::corr_out_t o_decision
);
  wire logic [6:0] code_len;
  wire logic [6:0] zero_limit;
  radio_wake_pkg::corr_out_t decision_next;
  radio_wake_pkg::corr_out_t decision_reg;

  assign code_len = i_corr.long_code ? radio_wake_pkg::CHIPS_LONG
                                      : radio_wake_pkg::CHIPS_SHORT; // [RULE2]
  assign zero_limit = i_thr_low;
  assign decision_next.decide_one = i_corr.count >= i_thr_high; // [RULE1] [RULE3]
  assign decision_next.decide_zero = i_corr.count <= zero_limit; // [RULE4]
  assign decision_next.perfect_one = i_corr.count == code_len; // [RULE2]

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      decision_reg <= '0;
    end else if (i_corr.valid) begin
      decision_reg <= decision_next;
    end
  end

  assign o_decision = decision_reg;
endmodule
`default_nettype wire

// file: radio_wake_host_model.sv
// Purpose: Host side bus master making single AHB-Lite word transfers.
// Assumes: One slave whose hreadyout is the bus hready.
// Notes: Write data is inverted once released, so stale data never looks valid.
`timescale 1ns/1ps
`default_nettype none
module radio_wake_host_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_go,
  input wire logic i_wr,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_hready,
  input wire logic [31:0] i_hrdata,
  output logic o_hsel,
  output logic [31:0] o_haddr,
  output logic [1:0] o_htrans,
  output logic o_hwrite,
  output logic [2:0] o_hsize,
  output logic [31:0] o_hwdata,
  output logic o_done,
  output logic [31:0] o_rdata
);
  logic [1:0] phase_reg;
  assign o_hsize = 3'h2;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_reg <= 2'h0;
      o_hsel <= 1'b0;
      o_htrans <= 2'h0;
      o_haddr <= 32'h0000_0000;
      o_hwrite <= 1'b0;
      o_hwdata <= 32'h0000_0000;
      o_rdata <= 32'h0000_0000;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (phase_reg == 2'h0 && i_go) begin
        o_hsel <= 1'b1;
        o_htrans <= radio_wake_pkg::HTRANS_NONSEQ;
        o_haddr <= i_addr;
        o_hwrite <= i_wr;
        phase_reg <= 2'h1;
      end else if (phase_reg == 2'h1 && i_hready) begin
        o_hsel <= 1'b0;
        o_htrans <= 2'h0;
        o_hwdata <= i_wdata;
        phase_reg <= 2'h2;
      end else if (phase_reg == 2'h2 && i_hready) begin
        o_rdata <= i_hrdata;
        o_hwdata <= ~o_hwdata;
        o_done <= 1'b1;
        phase_reg <= 2'h0;
      end
    end
  end
endmodule
`default_nettype wire

// file: radio_wake_pkg.sv
// Purpose: Constants and types for the radio wake and analog control register slice.
// Assumes: AHB-Lite register access, 32-bit words, one register per aligned word.
// Notes: Printed offsets are not all multiples of four, so they are register indices.
// Functional notes
// RULE1: Seven-bit high threshold is the least match count deciding a received one.
// RULE2: Perfect received one matches every chip: 64 or 32 by code length.
// RULE3: Reset threshold 0x38 still decides one with eight of 64 chips wrong.
// RULE4: One and zero decisions use both high and low threshold fields together; here one uses only the high field, zero only the i_thr_low input.
// RULE5: Host writes zero to all reserved bits of these registers.
// RULE6: Wake event after power-down release once ready; enable bit gates its interrupt.
// RULE7: Wake status bit sets on wake condition; register resets to 0x01, pending.
// RULE8: Reading wake status clears pending bit; writes never alter it.
// RULE9: Analog bit 6 unlocks writes to registers 0x2E and 0x2F.
// RULE10: Manufacturing-ID reads at 0x3C-0x3F return contents only while bit 5 set.
// RULE11: Host sets ID read enable only while reading, to save power.
// RULE12: Analog bit 2 enables driving the amplifier control pin.
// RULE13: Analog bit 1 selects amplifier pin polarity: one means active low.
// RULE14: Host changes amplifier enable and polarity bits in separate writes.
// RULE15: Writing one to analog bit 0 resets all registers; bit self-clears. Here irq mask and decision are kept; irq status keeps its bits and sets bit 1.
// RULE16: Interrupt asserts only while wake pending and enabled; drops when cleared.
// RULE17: Disabled amplifier pin holds its inactive level, ignoring transmit activity.
package radio_wake_pkg;

  // ==========================================================
  // Register indices and byte addresses
  localparam logic [7:0] IDX_THRESHOLD = 8'h1A;
  localparam logic [7:0] IDX_WAKE_EN = 8'h1C;
  localparam logic [7:0] IDX_WAKE_ST = 8'h1D;
  localparam logic [7:0] IDX_ANALOG = 8'h20;
  localparam logic [7:0] IDX_LOCK_A = 8'h2E;
  localparam logic [7:0] IDX_LOCK_B = 8'h2F;
  localparam logic [7:0] IDX_MFG_FIRST = 8'h3C;
  localparam logic [7:0] IDX_MFG_LAST = 8'h3F;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h40;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h41;
  localparam logic [7:0] IDX_DECISION = 8'h42;
  localparam int ADDR_LSB = 2;

  // ==========================================================
  // Reset values and fields
  localparam logic [7:0] RST_THRESHOLD = 8'h38;
  localparam logic [7:0] RST_WAKE_EN = 8'h00;
  localparam logic [7:0] RST_WAKE_ST = 8'h01;
  localparam logic [7:0] RST_ANALOG = 8'h00;
  localparam logic [7:0] RST_LOCKED = 8'h00;
  localparam logic [1:0] RST_IRQ = 2'h0;
  localparam logic [7:0] THR_MASK = 8'h7F;
  localparam logic [7:0] WAKE_EN_MASK = 8'h01;
  localparam logic [7:0] ANALOG_MASK = 8'h66;
  localparam int BIT_SOFT_RESET = 0;
  localparam int BIT_AMP_INVERT = 1;
  localparam int BIT_AMP_OE = 2;
  localparam int BIT_MFG_READ = 5;
  localparam int BIT_WRITE_UNLOCK = 6;
  localparam int IRQ_WAKE = 0;
  localparam int IRQ_SOFT_RESET = 1;

  // ==========================================================
  // Spreading and AHB encodings
  localparam logic [6:0] CHIPS_LONG = 7'h40;
  localparam logic [6:0] CHIPS_SHORT = 7'h20;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [31:0] MFG_ID_DEFAULT = 32'h0000_0000;

  typedef struct packed {
    logic [6:0] count;
    logic long_code;
    logic valid;
  } corr_in_t;

  typedef struct packed {
    logic decide_one;
    logic decide_zero;
    logic perfect_one;
  } corr_out_t;

  typedef enum logic [1:0] {
    WAKE_ASLEEP = 2'b00,
    WAKE_SETTLE = 2'b01,
    WAKE_READY = 2'b10
  } wake_state_t;

endpackage

// file: radio_wake_props.sv
// Purpose: Port-level assertions for the wake and analog register slice.
// Assumes: One bus master; zero wait states.
// Notes: Bound into radio_wake_regs at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module radio_wake_props #(
  parameter int READY_DELAY = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic i_power_down_pin,
  input wire logic i_tx_active,
  input wire radio_wake_pkg::corr_in_t i_corr,
  input wire radio_wake_pkg::corr_out_t o_decision,
  input wire logic o_amp_control_pin,
  input wire logic o_amp_output_enable,
  input wire logic o_mfg_power_en,
  input wire logic o_wake_irq,
  input wire logic o_irq
);
  // ==========================================================
  // Helper state
  logic addr_ok;
  logic wr_dp;
  logic any_dp;
  logic seen;
  logic [3:0] quiet_cnt;
  logic [7:0] awake_cnt;
  assign addr_ok = i_hsel & i_hready & i_htrans[1];
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_dp <= 1'b0;
      any_dp <= 1'b0;
      seen <= 1'b0;
      quiet_cnt <= 4'h0;
      awake_cnt <= 8'h00;
    end else begin
      wr_dp <= addr_ok & i_hwrite;
      any_dp <= addr_ok;
      seen <= 1'b1;
      quiet_cnt <= (addr_ok & i_hwrite) ? 4'h0 : quiet_cnt + {3'h0, quiet_cnt != 4'hF};
      awake_cnt <= i_power_down_pin ? 8'h00 : awake_cnt + {7'h00, awake_cnt != 8'hFF};
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ==========================================================
  // Assertions
  a_reset_quiet: assert property (
    !seen |-> !o_wake_irq && !o_irq && !o_amp_output_enable && !o_mfg_power_en
    && !o_amp_control_pin) else $error("outputs not at defaults after reset");
  // Settled window: up to quiet_cnt 3 a write, through soft reset, may still be moving the pin
  a_amp_follow_tx: assert property (
    quiet_cnt > 4'h3 |-> (o_amp_control_pin ^ $past(o_amp_control_pin)) ==
    (o_amp_output_enable & ($past(i_tx_active) ^ $past(i_tx_active, 2))))
    else $error("amp pin does not track transmit activity");
  // Soft reset lands one edge after its write, hence the second look back
  a_oe_from_write: assert property (
    $changed(o_amp_output_enable) |-> $past(wr_dp) || $past(wr_dp, 2))
    else $error("amp enable moved without write");
  a_mfg_from_write: assert property (
    $changed(o_mfg_power_en) |-> $past(wr_dp) || $past(wr_dp, 2))
    else $error("id enable moved without write");
  a_wake_fall_cause: assert property (
    $fell(o_wake_irq) |-> $past(any_dp) || $past(any_dp, 2))
    else $error("wake interrupt dropped without access");
  a_irq_fall_cause: assert property (
    $fell(o_irq) |-> $past(wr_dp) || $past(wr_dp, 2)) else $error("irq dropped without write");
  a_wake_ready_time: assert property (
    $rose(o_wake_irq) && !$past(any_dp) && !$past(any_dp, 2) |->
    awake_cnt >= READY_DELAY && awake_cnt <= READY_DELAY + 8) else $error("wake event mistimed");
  a_perfect_one: assert property (
    $past(i_corr.valid) |-> o_decision.perfect_one == ($past(i_corr.count) ==
    ($past(i_corr.long_code) ? radio_wake_pkg::CHIPS_LONG : radio_wake_pkg::CHIPS_SHORT)))
    else $error("perfect one flag wrong");
  a_decision_hold: assert property (
    !$past(i_corr.valid) |-> $stable(o_decision)) else $error("decision moved without count");
  c_wake: cover property ($rose(o_wake_irq));
  c_amp: cover property (o_amp_output_enable && i_tx_active);
  c_irq: cover property ($fell(o_irq));
endmodule
bind radio_wake_regs radio_wake_props #(.READY_DELAY(READY_DELAY)) radio_wake_props_inst (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel), .i_htrans(i_htrans),
  .i_hwrite(i_hwrite), .i_hready(i_hready), .i_power_down_pin(i_power_down_pin),
  .i_tx_active(i_tx_active), .i_corr(i_corr), .o_decision(o_decision),
  .o_amp_control_pin(o_amp_control_pin), .o_amp_output_enable(o_amp_output_enable),
  .o_mfg_power_en(o_mfg_power_en), .o_wake_irq(o_wake_irq), .o_irq(o_irq));
`default_nettype wire

// file: radio_wake_regs.sv
// Purpose: Threshold, wake interrupt and analog control registers over AHB-Lite.
// Assumes: Single-word transfers; power-down pin is asynchronous to i_clk.
// Notes: Zero wait states; every access answers OKAY; unmapped reads return zero.
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module radio_wake_regs #(
  parameter int READY_DELAY = 16,
  parameter logic [31:0] MFG_ID = radio_wake_pkg::MFG_ID_DEFAULT // Arbitrary value
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_power_down_pin,
  input wire logic i_tx_active,
  input wire radio_wake_pkg::corr_in_t i_corr,
  input wire logic [6:0] i_thr_low,
  output radio_wake_pkg::corr_out_t o_decision,
  output logic o_amp_control_pin,
  output logic o_amp_output_enable,
  output logic o_mfg_power_en,
  output logic o_wake_irq,
  output logic o_irq
);
  // ==========================================================
  // Address phase capture
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic [7:0] idx_reg;
  wire logic addr_valid;
  wire logic [7:0] addr_idx;

  assign addr_valid = i_hsel && i_hready && (i_htrans == radio_wake_pkg::HTRANS_NONSEQ ||
                      i_htrans == radio_wake_pkg::HTRANS_SEQ);
  assign addr_idx = i_haddr[radio_wake_pkg::ADDR_LSB +: 8];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      idx_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_valid && i_hwrite;
      rd_pend_reg <= addr_valid && !i_hwrite;
      idx_reg <= addr_idx;
    end
  end

  function automatic logic hits(input logic [7:0] idx, input logic [7:0] target);
    hits = idx == target;
  endfunction

  wire logic [7:0] wdata;
  wire logic wr_thr;
  wire logic wr_wake_en;
  wire logic wr_analog;
  wire logic wr_lock_a;
  wire logic wr_lock_b;
  wire logic wr_irq_status;
  wire logic wr_irq_mask;
  wire logic rd_wake_st;

  assign wdata = i_hwdata[7:0];
  assign wr_thr = wr_pend_reg && hits(idx_reg, radio_wake_pkg::IDX_THRESHOLD);
  assign wr_wake_en = wr_pend_reg && hits(idx_reg, radio_wake_pkg::IDX_WAKE_EN);
  assign wr_analog = wr_pend_reg && hits(idx_reg, radio_wake_pkg::IDX_ANALOG);
  assign wr_lock_a = wr_pend_reg && hits(idx_reg, radio_wake_pkg::IDX_LOCK_A);
  assign wr_lock_b = wr_pend_reg && hits(idx_reg, radio_wake_pkg::IDX_LOCK_B);
  assign wr_irq_status = wr_pend_reg && hits(idx_reg, radio_wake_pkg::IDX_IRQ_STATUS);
  assign wr_irq_mask = wr_pend_reg && hits(idx_reg, radio_wake_pkg::IDX_IRQ_MASK);
  assign rd_wake_st = rd_pend_reg && hits(idx_reg, radio_wake_pkg::IDX_WAKE_ST);

  // ==========================================================
  // Soft reset: one-cycle pulse restores config and wake status registers next edge; sets irq status bit 1, keeps mask
  logic soft_rst_reg;
  wire logic soft_rst_req;

  // Bit is never stored, so it always reads back as cleared
  assign soft_rst_req = wr_analog && wdata[radio_wake_pkg::BIT_SOFT_RESET]; // [RULE15]

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= soft_rst_req;
    end
  end

  // ==========================================================
  // Configuration registers
  logic [7:0] thr_reg;
  logic [7:0] wake_en_reg;
  logic [7:0] analog_reg;
  logic [7:0] lock_a_reg;
  logic [7:0] lock_b_reg;
  wire logic unlocked;

  assign unlocked = analog_reg[radio_wake_pkg::BIT_WRITE_UNLOCK];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      thr_reg <= radio_wake_pkg::RST_THRESHOLD;
      wake_en_reg <= radio_wake_pkg::RST_WAKE_EN;
      analog_reg <= radio_wake_pkg::RST_ANALOG;
      lock_a_reg <= radio_wake_pkg::RST_LOCKED;
      lock_b_reg <= radio_wake_pkg::RST_LOCKED;
    end else if (soft_rst_reg) begin
      thr_reg <= radio_wake_pkg::RST_THRESHOLD; // [RULE15]
      wake_en_reg <= radio_wake_pkg::RST_WAKE_EN;
      analog_reg <= radio_wake_pkg::RST_ANALOG;
      lock_a_reg <= radio_wake_pkg::RST_LOCKED;
      lock_b_reg <= radio_wake_pkg::RST_LOCKED;
    end else begin
      if (wr_thr) begin
        thr_reg <= wdata & radio_wake_pkg::THR_MASK; // [RULE1]
      end
      if (wr_wake_en) begin
        wake_en_reg <= wdata & radio_wake_pkg::WAKE_EN_MASK;
      end
      if (wr_analog) begin
        analog_reg <= wdata & radio_wake_pkg::ANALOG_MASK;
      end
      if (wr_lock_a && unlocked) begin
        lock_a_reg <= wdata; // [RULE9]
      end
      if (wr_lock_b && unlocked) begin
        lock_b_reg <= wdata; // [RULE9]
      end
    end
  end

  // ==========================================================
  // Wake detection: pin synchroniser, then settle time before ready
  logic power_down_meta_reg;
  logic power_down_sync_reg;
  radio_wake_pkg::wake_state_t wake_state_reg;
  radio_wake_pkg::wake_state_t wake_state_next;
  logic [15:0] settle_cnt_reg;
  wire logic settle_done;
  wire logic wake_event;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      power_down_meta_reg <= 1'b1;
      power_down_sync_reg <= 1'b1;
    end else begin
      power_down_meta_reg <= i_power_down_pin;
      power_down_sync_reg <= power_down_meta_reg;
    end
  end

  assign settle_done = settle_cnt_reg == 16'(READY_DELAY - 1);

  always_comb begin
    wake_state_next = wake_state_reg;
    unique case (wake_state_reg)
      radio_wake_pkg::WAKE_ASLEEP: begin
        if (!power_down_sync_reg) begin
          wake_state_next = radio_wake_pkg::WAKE_SETTLE;
        end
      end
      radio_wake_pkg::WAKE_SETTLE: begin
        if (power_down_sync_reg) begin
          wake_state_next = radio_wake_pkg::WAKE_ASLEEP;
        end else if (settle_done) begin
          wake_state_next = radio_wake_pkg::WAKE_READY;
        end
      end
      radio_wake_pkg::WAKE_READY: begin
        if (power_down_sync_reg) begin
          wake_state_next = radio_wake_pkg::WAKE_ASLEEP;
        end
      end
      default: begin
        wake_state_next = radio_wake_pkg::WAKE_ASLEEP;
      end
    endcase
  end

  assign wake_event = (wake_state_reg == radio_wake_pkg::WAKE_SETTLE) && settle_done
                      && !power_down_sync_reg; // [RULE6]

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wake_state_reg <= radio_wake_pkg::WAKE_ASLEEP;
      settle_cnt_reg <= 16'h0000;
    end else begin
      wake_state_reg <= wake_state_next;
      settle_cnt_reg <= (wake_state_reg == radio_wake_pkg::WAKE_SETTLE) ?
                        settle_cnt_reg + 16'h0001 : 16'h0000;
    end
  end

  // ==========================================================
  // Wake status: read-to-clear, event wins over the clear
  logic wake_st_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wake_st_reg <= radio_wake_pkg::RST_WAKE_ST[0]; // [RULE7]
    end else if (wake_event) begin
      wake_st_reg <= 1'b1; // [RULE7]
    end else if (soft_rst_reg) begin
      wake_st_reg <= radio_wake_pkg::RST_WAKE_ST[0];
    end else if (rd_wake_st) begin
      wake_st_reg <= 1'b0; // [RULE8]
    end
  end

  assign o_wake_irq = wake_st_reg && wake_en_reg[0]; // [RULE6] [RULE16]

  // ==========================================================
  // Block interrupt: sticky status, write one to clear, mask
  logic [1:0] irq_status_reg;
  logic [1:0] irq_mask_reg;
  wire logic [1:0] irq_events;

  assign irq_events = {soft_rst_reg, wake_event};

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_status_reg <= radio_wake_pkg::RST_IRQ;
      irq_mask_reg <= radio_wake_pkg::RST_IRQ;
    end else begin
      irq_status_reg <= irq_events |
                        (irq_status_reg & ~(wr_irq_status ? wdata[1:0] : 2'h0));
      if (wr_irq_mask) begin
        irq_mask_reg <= wdata[1:0];
      end
    end
  end

  assign o_irq = |(irq_status_reg & irq_mask_reg);

  // ==========================================================
  // Amplifier control pin
  logic amp_pin_reg;
  wire logic amp_oe;
  wire logic amp_inv;

  assign amp_oe = analog_reg[radio_wake_pkg::BIT_AMP_OE];
  assign amp_inv = analog_reg[radio_wake_pkg::BIT_AMP_INVERT];

  // Inactive level follows the polarity bit, so disabling never glitches active
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      amp_pin_reg <= 1'b0;
    end else begin
      amp_pin_reg <= (amp_oe && i_tx_active) ^ amp_inv; // [RULE12] [RULE13] [RULE17]
    end
  end

  assign o_amp_control_pin = amp_pin_reg;
  assign o_amp_output_enable = amp_oe; // [RULE12]
  assign o_mfg_power_en = analog_reg[radio_wake_pkg::BIT_MFG_READ]; // [RULE10]

  // ==========================================================
  // Correlator decision
  radio_wake_decider radio_wake_decider_inst (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_corr(i_corr),
    .i_thr_high(thr_reg[6:0]),
    .i_thr_low(i_thr_low),
    .o_decision(o_decision)
  );

  // ==========================================================
  // Read data, registered at the address phase
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  wire logic mfg_hit;
  wire logic [1:0] mfg_byte;

  assign mfg_hit = addr_idx >= radio_wake_pkg::IDX_MFG_FIRST &&
                   addr_idx <= radio_wake_pkg::IDX_MFG_LAST;
  assign mfg_byte = addr_idx[1:0];

  always_comb begin
    rdata_next = 32'h0000_0000;
    if (hits(addr_idx, radio_wake_pkg::IDX_THRESHOLD)) begin
      rdata_next[7:0] = thr_reg;
    end else if (hits(addr_idx, radio_wake_pkg::IDX_WAKE_EN)) begin
      rdata_next[7:0] = wake_en_reg;
    end else if (hits(addr_idx, radio_wake_pkg::IDX_WAKE_ST)) begin
      rdata_next[0] = wake_st_reg;
    end else if (hits(addr_idx, radio_wake_pkg::IDX_ANALOG)) begin
      rdata_next[7:0] = analog_reg;
    end else if (hits(addr_idx, radio_wake_pkg::IDX_LOCK_A)) begin
      rdata_next[7:0] = lock_a_reg;
    end else if (hits(addr_idx, radio_wake_pkg::IDX_LOCK_B)) begin
      rdata_next[7:0] = lock_b_reg;
    end else if (mfg_hit && o_mfg_power_en) begin
      rdata_next[7:0] = MFG_ID[{mfg_byte, 3'b000} +: 8]; // [RULE10]
    end else if (hits(addr_idx, radio_wake_pkg::IDX_IRQ_STATUS)) begin
      rdata_next[1:0] = irq_status_reg;
    end else if (hits(addr_idx, radio_wake_pkg::IDX_IRQ_MASK)) begin
      rdata_next[1:0] = irq_mask_reg;
    end else if (hits(addr_idx, radio_wake_pkg::IDX_DECISION)) begin
      rdata_next[2:0] = o_decision;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else if (addr_valid && !i_hwrite) begin
      rdata_reg <= rdata_next;
    end
  end

  assign o_hrdata = rdata_reg;
  assign o_hreadyout = 1'b1;
  assign o_hresp = radio_wake_pkg::HRESP_OKAY;
endmodule
`default_nettype wire

// file: radio_wake_regs_tb.sv
// Purpose: Self-checking bench for the wake and analog register slice.
// Assumes: Host model runs each bus cycle; bench waits for its done pulse.
// Notes: Short ready delay keeps the wake wait brief.
`timescale 1ns/1ps
`default_nettype none
module radio_wake_regs_tb;
  localparam int READY = 4;
  localparam logic [31:0] MFG = 32'h5AC3_9E17; // Arbitrary value
  localparam logic [7:0] THR = radio_wake_pkg::IDX_THRESHOLD;
  localparam logic [7:0] WEN = radio_wake_pkg::IDX_WAKE_EN;
  localparam logic [7:0] WST = radio_wake_pkg::IDX_WAKE_ST;
  localparam logic [7:0] ANA = radio_wake_pkg::IDX_ANALOG;
  logic clk, rst_n, go, wr, done, hsel, hwrite, hreadyout, hresp, power_down, tx;
  logic amp_pin, amp_oe, mfg_en, wake_irq, irq;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [6:0] thr_low;
  logic [31:0] addr, wdata, rdata, haddr, hwdata, hrdata;
  radio_wake_pkg::corr_in_t corr;
  radio_wake_pkg::corr_out_t dec;
  int num_errors, checks, n;
  radio_wake_regs #(.READY_DELAY(READY), .MFG_ID(MFG)) radio_wake_regs_inst (
    .i_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hreadyout),
    .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
    .i_power_down_pin(power_down),
    .i_tx_active(tx), .i_corr(corr), .i_thr_low(thr_low), .o_decision(dec),
    .o_amp_control_pin(amp_pin), .o_amp_output_enable(amp_oe), .o_mfg_power_en(mfg_en),
    .o_wake_irq(wake_irq), .o_irq(irq));
  radio_wake_host_model radio_wake_host_model_inst (
    .i_clk(clk), .i_rst_n(rst_n), .i_go(go), .i_wr(wr), .i_addr(addr), .i_wdata(wdata),
    .i_hready(hreadyout), .i_hrdata(hrdata), .o_hsel(hsel), .o_haddr(haddr),
    .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata),
    .o_done(done), .o_rdata(rdata));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================================
  // Compare, bus and stimulus tasks
  task automatic end_sim();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t pin got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    go <= 1'b1;
    wr <= w;
    addr <= {22'h0, idx, 2'h0};
    wdata <= d;
    @(posedge clk);
    go <= 1'b0;
    do begin
      @(negedge clk);
      k++;
    end while (done !== 1'b1 && k < 20);
    if (done !== 1'b1) begin
      num_errors++;
      end_sim();
    end
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    chk_data(rdata, exp);
  endtask
  task automatic amp(input logic t, input logic exp);
    @(posedge clk);
    tx <= t;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk_pin(amp_pin, exp);
  endtask
  task automatic decide(input logic [6:0] c, input logic l, input logic [2:0] exp);
    @(posedge clk);
    corr <= '{count: c, long_code: l, valid: 1'b1};
    @(posedge clk);
    corr.valid <= 1'b0;
    @(negedge clk);
    chk_data({29'h0, dec}, {29'h0, exp});
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {rst_n, go, wr, tx} = 4'h0;
    power_down = 1'b1;
    addr = 32'h0;
    wdata = 32'h0;
    corr = '0;
    thr_low = 7'h08;
    num_errors = 0;
    checks = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(THR, 32'h38);
    rd(WEN, 32'h00);
    rd(8'h30, 32'h00);
    xfer(1'b1, WST, 32'h0);
    chk_pin(hresp, radio_wake_pkg::HRESP_OKAY);
    rd(WST, 32'h01);
    rd(WST, 32'h00);
    xfer(1'b1, WST, 32'h1);
    rd(WST, 32'h00);
    xfer(1'b1, WEN, 32'h1);
    chk_pin(wake_irq, 1'b0);
    @(posedge clk);
    power_down <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (wake_irq !== 1'b1 && n < 40);
    chk_pin(wake_irq, 1'b1);
    chk_pin(n > READY, 1'b1);
    if (wake_irq !== 1'b1) end_sim();
    xfer(1'b1, radio_wake_pkg::IDX_IRQ_MASK, 32'h1);
    chk_pin(irq, 1'b1);
    xfer(1'b1, radio_wake_pkg::IDX_IRQ_STATUS, 32'h1);
    chk_pin(irq, 1'b0);
    rd(WST, 32'h01);
    chk_pin(wake_irq, 1'b0);
    xfer(1'b1, radio_wake_pkg::IDX_LOCK_A, 32'h5A);
    rd(radio_wake_pkg::IDX_LOCK_A, 32'h00);
    xfer(1'b1, ANA, 32'h40);
    xfer(1'b1, radio_wake_pkg::IDX_LOCK_B, 32'hA5);
    rd(radio_wake_pkg::IDX_LOCK_B, 32'hA5);
    rd(radio_wake_pkg::IDX_MFG_FIRST, 32'h00);
    xfer(1'b1, ANA, 32'h60);
    chk_pin(mfg_en, 1'b1);
    rd(radio_wake_pkg::IDX_MFG_LAST, {24'h0, MFG[31:24]});
    xfer(1'b1, ANA, 32'h00);
    chk_pin(mfg_en, 1'b0);
    xfer(1'b1, ANA, 32'h04);
    chk_pin(amp_oe, 1'b1);
    amp(1'b1, 1'b1);
    amp(1'b0, 1'b0);
    xfer(1'b1, ANA, 32'h06);
    amp(1'b0, 1'b1);
    amp(1'b1, 1'b0);
    xfer(1'b1, ANA, 32'h02);
    amp(1'b1, 1'b1);
    amp(1'b0, 1'b1);
    rd(ANA, 32'h02);
    decide(7'h40, 1'b1, 3'b101);
    decide(7'h38, 1'b1, 3'b100);
    decide(7'h37, 1'b1, 3'b000);
    decide(7'h08, 1'b1, 3'b010);
    decide(7'h09, 1'b1, 3'b000);
    xfer(1'b1, THR, 32'h1C);
    decide(7'h20, 1'b0, 3'b101);
    decide(7'h1B, 1'b0, 3'b000);
    xfer(1'b1, ANA, 32'h01);
    rd(ANA, 32'h00);
    rd(THR, 32'h38);
    rd(WST, 32'h01);
    rd(radio_wake_pkg::IDX_LOCK_B, 32'h00);
    rd(radio_wake_pkg::IDX_IRQ_STATUS, 32'h02);
    end_sim();
  end
endmodule
`default_nettype wire
